// file: rtl/buck_prot_pkg.sv
// Purpose: Shared constants and types for the buck protection and strap logic
// Assumes: core_clk at 10 MHz; straps arrive already resolved to three levels
// Notes: APB register map and timing counts live here
//
// Contract
// - Stop the power stage at over-temperature; resume only after hysteresis cooling.
// - Hold off high-side turn-on while valley current exceeds the low-side limit.
// - Valley limit strap: ground lowest, high middle, open highest level.
// - High-side limit trip ends the high-side on-time immediately.
// - Ignore the high-side comparator during blanking after each high-side turn-on.
// - Increment the 4-bit hiccup counter each cycle with a low-side limit event.
// - Otherwise decrement or hold at zero; saturate at both ends.
// - High-side limit events never change the hiccup counter.
// - At all ones, tri-state both switches for three soft-start durations.
// - After the hiccup wait, restart with a fresh soft-start.
// - Hiccup counting and shutdown stay active during soft-start too.
// - Rate strap: open lowest, ground middle, high highest frequency.
// - Decode the two output level straps into nine output voltage codes.
// - Each strap is a three-level input: low, high or open.
// - Latch straps once the analog supply settles; ignore later changes.
// - Soft-start ramps the reference at fixed slew; sets the hiccup wait base.
package buck_prot_pkg;

	// ----------------------------------------
	// Strap levels and decoded settings
	// ----------------------------------------
	typedef enum logic [1:0] {
		STRAP_LOW = 2'b00,
		STRAP_HIGH = 2'b01,
		STRAP_OPEN = 2'b10
	} strap_e;

	typedef struct packed {
		logic [1:0] limit_sel;
		logic [1:0] rate_sel;
		logic [3:0] level_sel;
	} strap_cfg_s;

	// Valley limit codes: 0 = 4.6 A, 1 = 6.2 A, 2 = 6.8 A
	localparam logic [1:0] LIMIT_LOWEST = 2'h0;
	localparam logic [1:0] LIMIT_MIDDLE = 2'h1;
	localparam logic [1:0] LIMIT_HIGHEST = 2'h2;
	// Rate codes: 0 = 400 kHz, 1 = 565 kHz, 2 = 790 kHz
	localparam logic [1:0] RATE_LOWEST = 2'h0;
	localparam logic [1:0] RATE_MIDDLE = 2'h1;
	localparam logic [1:0] RATE_HIGHEST = 2'h2;
	// Level codes 0..8: 3.3, 2.49, 1.8, 1.5, 1.2, 1.0, 0.9, 0.8, 0.7 V
	localparam logic [3:0] LEVEL_3V3 = 4'h0;
	localparam logic [3:0] LEVEL_2V49 = 4'h1;
	localparam logic [3:0] LEVEL_1V8 = 4'h2;
	localparam logic [3:0] LEVEL_1V5 = 4'h3;
	localparam logic [3:0] LEVEL_1V2 = 4'h4;
	localparam logic [3:0] LEVEL_1V0 = 4'h5;
	localparam logic [3:0] LEVEL_0V9 = 4'h6;
	localparam logic [3:0] LEVEL_0V8 = 4'h7;
	localparam logic [3:0] LEVEL_0V7 = 4'h8;

	// ----------------------------------------
	// Power stage state machine
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_SOFTSTART = 2'b01,
		ST_RUN = 2'b10,
		ST_HICCUP = 2'b11
	} stage_e;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int BLANK_NS = 108;
	localparam int BLANK_CYC_I = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [3:0] BLANK_CYC = 4'(BLANK_CYC_I);
	// Reference ramps at 0.45 V/ms up to a 0.7 V top; soft-start time in us
	localparam int SS_SLEW_UV_PER_MS = 450_000;
	localparam int SS_TOP_UV = 700_000;
	localparam int SS_US = (SS_TOP_UV * 1000) / SS_SLEW_UV_PER_MS;
	localparam int SS_CYC_DEF = SS_US * (CLK_HZ / 1_000_000);
	localparam int HICCUP_SS_COUNT = 3;
	localparam logic [3:0] HICCUP_FULL = 4'hF;
	localparam logic [3:0] HICCUP_ZERO = 4'h0;

	// ----------------------------------------
	// APB register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_CONTROL = 8'h0C;
	localparam logic [7:0] ADDR_STRAPS = 8'h10;
	// Event bits: 0 low-side limit, 1 high-side limit, 2 hiccup, 3 thermal
	localparam int EV_N = 4;
	localparam int EV_LS = 0;
	localparam int EV_HS = 1;
	localparam int EV_HICCUP = 2;
	localparam int EV_THERM = 3;
	localparam int CTRL_ENABLE = 0;
	localparam logic CTRL_RESET_VAL = 1'b1;
endpackage

// file: rtl/buck_prot.sv
// Purpose: Strap latch, current-limit gating, hiccup and thermal protection
// Assumes: Comparator and strap inputs synchronous to core_clk; cycle_tick marks each switching cycle
// Notes: APB slave, zero wait states; unmapped reads return zero, slverr on unmapped
module buck_prot #(
	parameter int SS_CYC = buck_prot_pkg::SS_CYC_DEF
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic supply_good,
	input wire logic [1:0] valley_limit_strap,
	input wire logic [1:0] switching_rate_strap,
	input wire logic [1:0] output_level_select_high,
	input wire logic [1:0] output_level_select_low,
	input wire logic over_temp,
	input wire logic cycle_tick,
	input wire logic pwm_on_req,
	input wire logic pwm_off_req,
	input wire logic ls_limit,
	input wire logic hs_limit,
	output logic hs_gate,
	output logic ls_gate,
	output logic stage_tristate,
	output logic softstart_active,
	output buck_prot_pkg::strap_cfg_s strap_cfg,
	output logic irq
);

	// ----------------------------------------
	// Strap latch
	// ----------------------------------------
	logic straps_taken_q;
	buck_prot_pkg::strap_cfg_s cfg_d;
	buck_prot_pkg::strap_e lvl_hi;
	buck_prot_pkg::strap_e lvl_lo;

	always_comb begin
		lvl_hi = buck_prot_pkg::strap_e'(output_level_select_high);
		lvl_lo = buck_prot_pkg::strap_e'(output_level_select_low);
		// ground, high and open map to three valley limits
		if (valley_limit_strap == buck_prot_pkg::STRAP_LOW) begin
			cfg_d.limit_sel = buck_prot_pkg::LIMIT_LOWEST;
		end else if (valley_limit_strap == buck_prot_pkg::STRAP_HIGH) begin
			cfg_d.limit_sel = buck_prot_pkg::LIMIT_MIDDLE;
		end else begin
			cfg_d.limit_sel = buck_prot_pkg::LIMIT_HIGHEST;
		end
		if (switching_rate_strap == buck_prot_pkg::STRAP_LOW) begin
			cfg_d.rate_sel = buck_prot_pkg::RATE_MIDDLE;
		end else if (switching_rate_strap == buck_prot_pkg::STRAP_HIGH) begin
			cfg_d.rate_sel = buck_prot_pkg::RATE_HIGHEST;
		end else begin
			cfg_d.rate_sel = buck_prot_pkg::RATE_LOWEST;
		end
		case ({lvl_hi, lvl_lo})
			{buck_prot_pkg::STRAP_LOW, buck_prot_pkg::STRAP_LOW}: cfg_d.level_sel = buck_prot_pkg::LEVEL_3V3;
			{buck_prot_pkg::STRAP_LOW, buck_prot_pkg::STRAP_HIGH}: cfg_d.level_sel = buck_prot_pkg::LEVEL_2V49;
			{buck_prot_pkg::STRAP_HIGH, buck_prot_pkg::STRAP_LOW}: cfg_d.level_sel = buck_prot_pkg::LEVEL_1V8;
			{buck_prot_pkg::STRAP_HIGH, buck_prot_pkg::STRAP_HIGH}: cfg_d.level_sel = buck_prot_pkg::LEVEL_1V5;
			{buck_prot_pkg::STRAP_LOW, buck_prot_pkg::STRAP_OPEN}: cfg_d.level_sel = buck_prot_pkg::LEVEL_1V2;
			{buck_prot_pkg::STRAP_OPEN, buck_prot_pkg::STRAP_LOW}: cfg_d.level_sel = buck_prot_pkg::LEVEL_1V0;
			{buck_prot_pkg::STRAP_HIGH, buck_prot_pkg::STRAP_OPEN}: cfg_d.level_sel = buck_prot_pkg::LEVEL_0V9;
			{buck_prot_pkg::STRAP_OPEN, buck_prot_pkg::STRAP_HIGH}: cfg_d.level_sel = buck_prot_pkg::LEVEL_0V8;
			default: cfg_d.level_sel = buck_prot_pkg::LEVEL_0V7;
		endcase
	end

	// Captured once after the supply settles; later pin changes have no effect
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			straps_taken_q <= 1'b0;
			strap_cfg <= '0;
		end else if (supply_good && !straps_taken_q) begin
			straps_taken_q <= 1'b1;
			strap_cfg <= cfg_d;
		end
	end

	// ----------------------------------------
	// Thermal state
	// ----------------------------------------
	// over_temp is the comparator with 160 C trip and 25 C hysteresis built in
	logic therm_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			therm_q <= 1'b0;
		end else begin
			therm_q <= over_temp;
		end
	end

	// ----------------------------------------
	// Stage sequencing
	// ----------------------------------------
	buck_prot_pkg::stage_e state_q;
	logic [31:0] wait_q;
	logic [3:0] hiccup_q;
	logic enable_q;
	logic ls_evt_q;
	logic hiccup_trip;
	assign hiccup_trip = (hiccup_q == buck_prot_pkg::HICCUP_FULL);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= buck_prot_pkg::ST_OFF;
			wait_q <= '0;
		end else begin
			case (state_q)
				buck_prot_pkg::ST_OFF: begin
					// restart only through soft-start once hot flag clears
					if (straps_taken_q && enable_q && !therm_q) begin
						state_q <= buck_prot_pkg::ST_SOFTSTART;
						wait_q <= 32'(SS_CYC);
					end
				end
				buck_prot_pkg::ST_SOFTSTART: begin
					if (therm_q || !enable_q) begin
						state_q <= buck_prot_pkg::ST_OFF;
					end else if (hiccup_trip) begin
						state_q <= buck_prot_pkg::ST_HICCUP;
						wait_q <= 32'(buck_prot_pkg::HICCUP_SS_COUNT * SS_CYC);
					end else if (wait_q <= 32'd1) begin
						state_q <= buck_prot_pkg::ST_RUN;
					end else begin
						wait_q <= wait_q - 32'd1;
					end
				end
				buck_prot_pkg::ST_RUN: begin
					if (therm_q || !enable_q) begin
						state_q <= buck_prot_pkg::ST_OFF;
					end else if (hiccup_trip) begin
						state_q <= buck_prot_pkg::ST_HICCUP;
						wait_q <= 32'(buck_prot_pkg::HICCUP_SS_COUNT * SS_CYC);
					end
				end
				default: begin
					if (wait_q <= 32'd1) begin
						state_q <= buck_prot_pkg::ST_OFF;
					end else begin
						wait_q <= wait_q - 32'd1;
					end
				end
			endcase
		end
	end

	logic active;
	assign active = (state_q == buck_prot_pkg::ST_SOFTSTART) || (state_q == buck_prot_pkg::ST_RUN);

	// ----------------------------------------
	// Hiccup counter
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ls_evt_q <= 1'b0;
			hiccup_q <= buck_prot_pkg::HICCUP_ZERO;
		end else if (!active) begin
			ls_evt_q <= 1'b0;
			hiccup_q <= buck_prot_pkg::HICCUP_ZERO;
		end else if (cycle_tick) begin
			// A limit seen on the tick edge closes this cycle; carrying it over would count twice
			ls_evt_q <= 1'b0;
			// hs_limit has no path into this counter
			if (ls_evt_q || ls_limit) begin
				if (!hiccup_trip) begin
					hiccup_q <= hiccup_q + 4'h1;
				end
			end else if (hiccup_q != buck_prot_pkg::HICCUP_ZERO) begin
				hiccup_q <= hiccup_q - 4'h1;
			end
		end else if (ls_limit) begin
			ls_evt_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// High-side gate with blanking
	// ----------------------------------------
	logic [3:0] blank_q;
	logic hs_trip;
	assign hs_trip = hs_gate && (blank_q == 4'h0) && hs_limit;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_gate <= 1'b0;
			ls_gate <= 1'b0;
			blank_q <= '0;
		end else if (!active || hiccup_trip) begin
			hs_gate <= 1'b0;
			ls_gate <= 1'b0;
			blank_q <= '0;
		end else if (hs_gate) begin
			if (blank_q != 4'h0) begin
				blank_q <= blank_q - 4'h1;
			end
			if (hs_trip || pwm_off_req) begin
				hs_gate <= 1'b0;
				ls_gate <= 1'b1;
			end
		end else if (pwm_on_req && !ls_limit && !hiccup_trip) begin
			hs_gate <= 1'b1;
			ls_gate <= 1'b0;
			blank_q <= buck_prot_pkg::BLANK_CYC;
		end else begin
			ls_gate <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_tristate <= 1'b1;
			softstart_active <= 1'b0;
		end else begin
			stage_tristate <= !active || hiccup_trip;
			softstart_active <= (state_q == buck_prot_pkg::ST_SOFTSTART);
		end
	end

	// ----------------------------------------
	// Interrupts and APB
	// ----------------------------------------
	logic [buck_prot_pkg::EV_N-1:0] ev_stat_q;
	logic [buck_prot_pkg::EV_N-1:0] ev_mask_q;
	logic [buck_prot_pkg::EV_N-1:0] ev_now;
	logic wr_acc;
	logic rd_acc;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign ev_now[buck_prot_pkg::EV_LS] = active && ls_limit;
	assign ev_now[buck_prot_pkg::EV_HS] = hs_trip;
	assign ev_now[buck_prot_pkg::EV_HICCUP] = active && hiccup_trip;
	assign ev_now[buck_prot_pkg::EV_THERM] = over_temp && !therm_q;

	// Set wins over a write-one clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < buck_prot_pkg::EV_N; gi++) begin : g_ev
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					ev_stat_q[gi] <= 1'b0;
				end else if (ev_now[gi]) begin
					ev_stat_q[gi] <= 1'b1;
				end else if (wr_acc && paddr == buck_prot_pkg::ADDR_IRQ_STAT && pwdata[gi]) begin
					ev_stat_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_mask_q <= '0;
			enable_q <= buck_prot_pkg::CTRL_RESET_VAL;
			irq <= 1'b0;
		end else begin
			if (wr_acc && paddr == buck_prot_pkg::ADDR_IRQ_MASK) begin
				ev_mask_q <= pwdata[buck_prot_pkg::EV_N-1:0];
			end
			if (wr_acc && paddr == buck_prot_pkg::ADDR_CONTROL) begin
				enable_q <= pwdata[buck_prot_pkg::CTRL_ENABLE];
			end
			irq <= |(ev_stat_q & ev_mask_q);
		end
	end

	logic mapped;
	assign mapped = (paddr == buck_prot_pkg::ADDR_STATUS) || (paddr == buck_prot_pkg::ADDR_IRQ_STAT)
		|| (paddr == buck_prot_pkg::ADDR_IRQ_MASK) || (paddr == buck_prot_pkg::ADDR_CONTROL)
		|| (paddr == buck_prot_pkg::ADDR_STRAPS);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= '0;
			if (psel && !penable && !pwrite) begin
				if (paddr == buck_prot_pkg::ADDR_STATUS) begin
					prdata <= {20'h00000, hiccup_q, 2'h0, straps_taken_q, therm_q, 2'h0, state_q};
				end else if (paddr == buck_prot_pkg::ADDR_IRQ_STAT) begin
					prdata <= {28'h0000000, ev_stat_q};
				end else if (paddr == buck_prot_pkg::ADDR_IRQ_MASK) begin
					prdata <= {28'h0000000, ev_mask_q};
				end else if (paddr == buck_prot_pkg::ADDR_CONTROL) begin
					prdata <= {31'h00000000, enable_q};
				end else if (paddr == buck_prot_pkg::ADDR_STRAPS) begin
					prdata <= {24'h000000, strap_cfg};
				end
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	hiccup_sat_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cycle_tick && active && !ls_limit && !ls_evt_q && hiccup_q == 4'h0) |=> hiccup_q == 4'h0)
		else $error("hiccup counter wrapped below zero");
	hiccup_inc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cycle_tick && active && ls_limit && hiccup_q < 4'hE) |=> hiccup_q == $past(hiccup_q) + 4'h1)
		else $error("hiccup counter missed a low-side event");
	hiccup_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(active && hiccup_trip) |=> state_q == buck_prot_pkg::ST_HICCUP ##1 stage_tristate)
		else $error("full hiccup count did not shut the stage");
	ls_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!hs_gate && ls_limit) |=> !hs_gate)
		else $error("high side turned on above valley limit");
	hs_trunc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		hs_trip |=> !hs_gate && (ls_gate || stage_tristate))
		else $error("high-side trip did not end on-time");
	blank_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(hs_gate) && !pwm_off_req |-> ##1 (hs_gate || pwm_off_req || !active))
		else $error("high side cut inside blanking");
	therm_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(therm_q && active) |=> state_q == buck_prot_pkg::ST_OFF ##1 stage_tristate)
		else $error("thermal trip did not stop stage");
	strap_freeze_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		straps_taken_q |=> strap_cfg == $past(strap_cfg))
		else $error("strap settings changed after latch");
	retry_ss_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == buck_prot_pkg::ST_HICCUP && wait_q <= 32'd1) |=> state_q == buck_prot_pkg::ST_OFF)
		else $error("hiccup wait did not end in retry");
	count_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == buck_prot_pkg::ST_OFF) |=> hiccup_q == 4'h0)
		else $error("hiccup count not cleared before retry");
endmodule

// file: verif/power_stage_model.sv
// Purpose: Behavioural power stage, sense comparators and modulator clock
// Assumes: Comparator outputs are levels synchronous to core_clk
// Notes: Overload flags from the bench stand in for a shorted output
module power_stage_model #(
	parameter int TICK_CYC = 10
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hs_gate,
	input wire logic stage_tristate,
	input wire logic ls_over,
	input wire logic hs_over,
	output logic cycle_tick,
	output logic pwm_on_req,
	output logic pwm_off_req,
	output logic ls_limit,
	output logic hs_limit
);
	timeunit 1ns;
	timeprecision 1ns;
	int phase;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			phase <= 0;
		else
			phase <= (phase == TICK_CYC - 1) ? 0 : phase + 1;
	end
	assign cycle_tick = (phase == 0);
	assign pwm_off_req = (phase == 0);
	assign pwm_on_req = (phase >= TICK_CYC / 2);
	// A hard short keeps the valley current high even with both switches off
	assign ls_limit = ls_over;
	// High-side sense only sees current while its switch conducts
	assign hs_limit = hs_gate & !stage_tristate & hs_over;
endmodule

// file: verif/buck_protection_and_strap_logic_tb_top.sv
// Purpose: Self-checking bench for the protection and strap block
// Assumes: SS_CYC shortened to 200 cycles; ten-cycle switching period
// Notes: Random strap and count values from a fixed seed
module buck_protection_and_strap_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SS = 200;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, supply_good = 1'b0, over_temp = 1'b0;
	logic [1:0] lim_s = 2'h0, rate_s = 2'h0, vh = 2'h0, vl = 2'h0;
	logic tick, on_req, off_req, ls_limit, hs_limit, hs_gate, ls_gate, tri_st, ss_act, irq;
	logic ls_over = 1'b0, hs_over = 1'b0, ls_q = 1'b0;
	buck_prot_pkg::strap_cfg_s strap_cfg;
	int error_cnt = 0, n_compared = 0, cyc = 0, hs_in_ls = 0, k, n, m;
	logic [3:0] lv_pair [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h2, 4'h8, 4'h6, 4'h9, 4'hA};

	buck_prot #(.SS_CYC(SS)) DUT (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .supply_good(supply_good),
		.valley_limit_strap(lim_s), .switching_rate_strap(rate_s),
		.output_level_select_high(vh), .output_level_select_low(vl),
		.over_temp(over_temp), .cycle_tick(tick), .pwm_on_req(on_req),
		.pwm_off_req(off_req), .ls_limit(ls_limit), .hs_limit(hs_limit), .hs_gate(hs_gate),
		.ls_gate(ls_gate), .stage_tristate(tri_st), .softstart_active(ss_act),
		.strap_cfg(strap_cfg), .irq(irq));
	power_stage_model PS (.core_clk(core_clk), .rst_n(rst_n), .hs_gate(hs_gate),
		.stage_tristate(tri_st), .ls_over(ls_over), .hs_over(hs_over), .cycle_tick(tick),
		.pwm_on_req(on_req), .pwm_off_req(off_req), .ls_limit(ls_limit),
		.hs_limit(hs_limit));

	always #50 core_clk = ~core_clk;
	// ----------------------------------------
	// Watchdog and monitors
	// ----------------------------------------
	always @(posedge core_clk) begin
		cyc++;
		if (ls_q && ls_over && hs_gate === 1'b1)
			hs_in_ls++;
		ls_q <= ls_over;
		if (cyc == 6000) begin
			error_cnt++;
			final_report();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Starts after an edge so a release and the next setup never share a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the cycle watchdog may end this wait
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_tick();
		do
			@(posedge core_clk);
		while (tick !== 1'b1);
	endtask
	task automatic do_reset(input int c);
		rst_n <= 1'b0;
		repeat (c) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask
	function automatic logic [1:0] lim_of(input logic [1:0] s);
		if (s == 2'h0)
			return buck_prot_pkg::LIMIT_LOWEST;
		return (s == 2'h1) ? buck_prot_pkg::LIMIT_MIDDLE : buck_prot_pkg::LIMIT_HIGHEST;
	endfunction
	function automatic logic [1:0] rate_of(input logic [1:0] s);
		if (s == 2'h2)
			return buck_prot_pkg::RATE_LOWEST;
		return (s == 2'h0) ? buck_prot_pkg::RATE_MIDDLE : buck_prot_pkg::RATE_HIGHEST;
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(69));
		repeat (20) @(posedge core_clk);
		chk(32'(tri_st), 32'h1);
		$display("reset test done");
		for (int i = 0; i < 9; i++) begin
			supply_good <= 1'b0;
			do_reset(2);
			{vh, vl} <= lv_pair[i];
			lim_s <= 2'(i % 3);
			rate_s <= 2'(i / 3);
			repeat (2) @(posedge core_clk);
			supply_good <= 1'b1;
			repeat (4) @(posedge core_clk);
			chk({24'h0, strap_cfg}, {24'h0, lim_of(2'(i % 3)), rate_of(2'(i / 3)), 4'(i)});
			lim_s <= 2'($urandom % 3);
			{vh, vl} <= lv_pair[$urandom % 9];
			apb(1'b0, buck_prot_pkg::ADDR_STRAPS, 32'h0);
			chk(rd, {24'h0, lim_of(2'(i % 3)), rate_of(2'(i / 3)), 4'(i)});
		end
		$display("strap test done");
		apb(1'b0, buck_prot_pkg::ADDR_CONTROL, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("register test done");
		n = 3 + ($urandom % 8);
		m = 1 + ($urandom % 12);
		wait_tick();
		ls_over <= 1'b1;
		repeat (n) wait_tick();
		ls_over <= 1'b0;
		hs_over <= 1'b1;
		apb(1'b0, buck_prot_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[11:8]), 32'(n));
		chk(32'(hs_in_ls), 32'h0);
		repeat (m) wait_tick();
		apb(1'b0, buck_prot_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[11:8]), (n > m) ? 32'(n - m) : 32'h0);
		for (k = 0; k < 30 && hs_gate !== 1'b0; k++) @(posedge core_clk);
		for (k = 0; k < 30 && hs_gate !== 1'b1; k++) @(posedge core_clk);
		for (k = 0; k < 20 && hs_gate === 1'b1; k++) @(posedge core_clk);
		chk(32'(k), 32'(buck_prot_pkg::BLANK_CYC) + 32'h1);
		hs_over <= 1'b0;
		$display("limit test done");
		do_reset(2);
		ls_over <= 1'b1;
		apb(1'b1, buck_prot_pkg::ADDR_IRQ_MASK, 32'h0000000C);
		for (k = 0; k < 40 && ss_act !== 1'b1; k++) @(posedge core_clk);
		for (k = 0; k < 190 && tri_st !== 1'b1; k++) @(posedge core_clk);
		ls_over <= 1'b0;
		chk(32'(k < 190), 32'h1);
		chk({29'h0, tri_st, hs_gate, ls_gate}, 32'h4);
		repeat (3 * SS - 12) @(posedge core_clk);
		chk({31'h0, tri_st}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		for (k = 0; k < 30 && ss_act !== 1'b1; k++) @(posedge core_clk);
		chk({31'h0, ss_act}, 32'h1);
		apb(1'b0, buck_prot_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[11:8]), 32'h0);
		$display("hiccup test done");
		apb(1'b1, buck_prot_pkg::ADDR_IRQ_STAT, 32'h0000000F);
		over_temp <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({29'h0, tri_st, hs_gate, ls_gate}, 32'h4);
		apb(1'b0, buck_prot_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd & 32'h8, 32'h8);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, buck_prot_pkg::ADDR_IRQ_MASK, 32'h0);
		// Mask lands on the access edge; irq follows one edge later
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		over_temp <= 1'b0;
		for (k = 0; k < 10 && ss_act !== 1'b1; k++) @(posedge core_clk);
		chk({31'h0, ss_act}, 32'h1);
		apb(1'b1, buck_prot_pkg::ADDR_IRQ_STAT, 32'h0000000F);
		apb(1'b0, buck_prot_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd & 32'h8, 32'h0);
		$display("thermal test done");
		final_report();
	end
endmodule
